//--- verilog/acc_pkg.sv
// Purpose: Shared constants for the converter control block
// Assumes: One state time equals one i_clk cycle
// Notes:   Offsets are byte addresses on the register port
package acc_pkg;
  localparam int unsigned RES_BITS      = 10;
  localparam int unsigned CHAN_BITS     = 3;
  localparam int unsigned ADDR_BITS     = 8;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned STATE_CLKS    = 1;
  localparam int unsigned CONV_STATES   = 88;
  localparam int unsigned SAMPLE_STATES = 4;
  localparam int unsigned BIT_STATES    = 8;
  localparam int unsigned STATUS_WAIT   = 8;
  localparam int unsigned CONV_CLKS     = CONV_STATES * STATE_CLKS;
  localparam int unsigned SAMPLE_CLKS   = SAMPLE_STATES * STATE_CLKS;
  localparam int unsigned BIT_CLKS      = BIT_STATES * STATE_CLKS;
  localparam int unsigned CNT_BITS      = 7;

  localparam logic [7:0] ADR_CMD_RES_LO = 8'h02;
  localparam logic [7:0] ADR_RES_HI     = 8'h03;

  localparam int unsigned CMD_CH_LSB  = 0;
  localparam int unsigned CMD_GO_BIT  = 3;
  localparam int unsigned RES_CH_LSB  = 0;
  localparam int unsigned RES_BSY_BIT = 3;
  localparam int unsigned RES_LO_LSB  = 6;

  typedef enum logic [2:0] {
    ACC_IDLE    = 3'b001,
    ACC_SAMPLE  = 3'b010,
    ACC_CONVERT = 3'b100
  } acc_state_e;
endpackage

//--- verilog/acc_sync.sv
// Purpose: Three-stage synchroniser for an asynchronous pin
// Assumes: Pin level is steady for at least three clocks per change
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module acc_sync (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_pin,
  output logic      o_level
);
  logic s1_r, s2_r, s3_r, lvl_r;
  logic lvl_nxt;

  always_comb begin
    lvl_nxt = lvl_r;
    if (s2_r == s3_r) begin
      lvl_nxt = s3_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r  <= i_pin;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign o_level = lvl_r;
endmodule // acc_sync

//--- verilog/acc_sar.sv
// Purpose: Successive-approximation code register
// Assumes: Comparator high means the input is at or above the trial level
// Notes:   Clear wins over trial and decide in the same cycle
`timescale 1ns/1ps
module acc_sar
  import acc_pkg::*;
#(
  parameter int unsigned WIDTH = RES_BITS
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_nrst,
  input  wire logic                     i_clr,
  input  wire logic                     i_trial,
  input  wire logic                     i_decide,
  input  wire logic [3:0]               i_idx,
  input  wire logic                     i_cmp,
  output logic      [WIDTH-1:0]         o_code
);
  logic [WIDTH-1:0] code_r, code_nxt;

  initial begin
    if (WIDTH < 2 || WIDTH > 16) begin
      $error("acc_sar: WIDTH out of range");
    end
  end

  always_comb begin
    code_nxt = code_r;
    if (i_clr) begin
      code_nxt = '0;
    end else if (i_trial) begin
      code_nxt[i_idx] = 1'b1;
    end else if (i_decide && !i_cmp) begin
      code_nxt[i_idx] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      code_r <= '0;
    end else begin
      code_r <= code_nxt;
    end
  end

  assign o_code = code_r;
endmodule // acc_sar

//--- verilog/acc_ctrl.sv
// Purpose: Conversion sequencing and register port for a 10-bit SAR converter
// Assumes: One state time per i_clk; timed-event start arrives as a one-cycle pulse
// Notes:   Analog front end lives outside; this drives sample, mux and trial code
// Behaviour
// - Each conversion lasts exactly 88 state times, whatever channel or input.
// - Sample window is open 4 state times, inside the 88.
// - Result is 10 bits scaled by 1023; full-scale input gives all ones.
// - Writing command register at 02h selects one of eight analog inputs.
// - Command starts now or waits for the timed-event start pulse.
// - Command is double buffered; may be written while converting.
// - A new start abandons the running conversion and restarts at once.
// - Result register is cleared at the start of every conversion.
// - Result read as separate bytes at 02h and 03h.
// - Status bit is set within 8 state times of a start.
// - Timed start may raise the timer interrupt but sets no flag.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module acc_ctrl
  import acc_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire logic [ADDR_BITS-1:0] i_addr,
  input  wire logic [DATA_BITS-1:0] i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [DATA_BITS-1:0] o_rdata,
  input  wire logic                 i_evt_start,
  input  wire logic                 i_evt_irq,
  input  wire logic                 i_cmp,
  output logic      [CHAN_BITS-1:0] o_chan_sel,
  output logic                      o_sample,
  output logic      [RES_BITS-1:0]  o_dac_code,
  output logic                      o_busy,
  output logic                      o_swt_irq
);
  acc_state_e state_r, state_nxt;
  logic [CNT_BITS-1:0]  cnt_r, cnt_nxt;
  logic [CHAN_BITS-1:0] pend_ch_r, pend_ch_nxt;
  logic                 pend_r, pend_nxt;
  logic [CHAN_BITS-1:0] chan_r, chan_nxt;
  logic [RES_BITS-1:0]  res_r, res_nxt;
  logic                 busy_r, busy_nxt;
  logic                 sample_r, sample_nxt;
  logic [DATA_BITS-1:0] rdata_r, rdata_nxt;
  logic                 swt_r, swt_nxt;
  logic                 wr_cmd, go_now, evt_go, start, done;
  logic [CHAN_BITS-1:0] start_ch;
  logic                 trial, decide, cmp_lvl;
  logic [3:0]           bit_idx;
  logic [RES_BITS-1:0]  code;

  // Bit slot and phase inside the approximation phase
  function automatic logic [3:0] slot_of(input logic [CNT_BITS-1:0] c);
    logic [CNT_BITS-1:0] off;
    off = c - CNT_BITS'(SAMPLE_CLKS);
    return 4'(off / CNT_BITS'(BIT_CLKS));
  endfunction

  function automatic logic [CNT_BITS-1:0] phase_of(input logic [CNT_BITS-1:0] c);
    logic [CNT_BITS-1:0] off;
    off = c - CNT_BITS'(SAMPLE_CLKS);
    return off % CNT_BITS'(BIT_CLKS);
  endfunction

  initial begin
    if (SAMPLE_CLKS + RES_BITS * BIT_CLKS > CONV_CLKS || CONV_CLKS >= (1 << CNT_BITS)) begin
      $error("acc_ctrl: conversion timing does not fit");
    end
  end

  acc_sync u_cmp_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_pin   (i_cmp),
    .o_level (cmp_lvl)
  );

  acc_sar #(.WIDTH(RES_BITS)) u_sar (
    .i_clk    (i_clk),
    .i_nrst   (i_nrst),
    .i_clr    (start),
    .i_trial  (trial),
    .i_decide (decide),
    .i_idx    (bit_idx),
    .i_cmp    (cmp_lvl),
    .o_code   (code)
  );

  // Start decode: a fresh write wins over a timed event in the same cycle
  always_comb begin
    wr_cmd   = i_wr && (i_addr == ADR_CMD_RES_LO);
    go_now   = wr_cmd && i_wdata[CMD_GO_BIT];
    evt_go   = i_evt_start && pend_r && !wr_cmd;
    start    = go_now || evt_go;
    start_ch = go_now ? i_wdata[CMD_CH_LSB +: CHAN_BITS] : pend_ch_r;
  end

  // Holding register for a deferred command, armed once per write
  always_comb begin
    pend_nxt    = pend_r;
    pend_ch_nxt = pend_ch_r;
    if (wr_cmd) begin
      pend_nxt    = !i_wdata[CMD_GO_BIT];
      pend_ch_nxt = i_wdata[CMD_CH_LSB +: CHAN_BITS];
    end else if (evt_go) begin
      pend_nxt = 1'b0;
    end
  end

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    chan_nxt  = chan_r;
    done      = 1'b0;
    if (start) begin
      state_nxt = ACC_SAMPLE;
      cnt_nxt   = '0;
      chan_nxt  = start_ch;
    end else begin
      case (state_r)
        ACC_IDLE: begin
          cnt_nxt = '0;
        end
        ACC_SAMPLE: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CNT_BITS'(SAMPLE_CLKS - 1)) begin
            state_nxt = ACC_CONVERT;
          end
        end
        ACC_CONVERT: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CNT_BITS'(CONV_CLKS - 1)) begin
            done      = 1'b1;
            state_nxt = ACC_IDLE;
            cnt_nxt   = '0;
          end
        end
        default: begin
          state_nxt = ACC_IDLE;
          cnt_nxt   = '0;
        end
      endcase
    end
  end

  // Trial bit set at slot start, kept or dropped at slot end
  always_comb begin
    bit_idx = 4'(RES_BITS - 1) - slot_of(cnt_r);
    trial   = 1'b0;
    decide  = 1'b0;
    if (state_r == ACC_CONVERT && !start &&
        cnt_r < CNT_BITS'(SAMPLE_CLKS + RES_BITS * BIT_CLKS)) begin
      trial  = (phase_of(cnt_r) == '0);
      decide = (phase_of(cnt_r) == CNT_BITS'(BIT_CLKS - 1));
    end
  end

  // Result and status
  always_comb begin
    res_nxt    = res_r;
    busy_nxt   = busy_r;
    sample_nxt = (state_nxt == ACC_SAMPLE);
    swt_nxt    = evt_go && i_evt_irq;
    if (start) begin
      res_nxt  = '0;
      busy_nxt = 1'b1;
    end else if (done) begin
      res_nxt  = code;
      busy_nxt = 1'b0;
    end
  end

  // Byte reads only; a word read is not supported by this port
  always_comb begin
    rdata_nxt = '0;
    if (i_rd) begin
      case (i_addr)
        ADR_CMD_RES_LO: begin
          rdata_nxt[RES_LO_LSB +: 2]         = res_r[1:0];
          rdata_nxt[RES_BSY_BIT]             = busy_r;
          rdata_nxt[RES_CH_LSB +: CHAN_BITS] = chan_r;
        end
        ADR_RES_HI: begin
          rdata_nxt = res_r[RES_BITS-1:2];
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r   <= ACC_IDLE;
      cnt_r     <= '0;
      pend_r    <= 1'b0;
      pend_ch_r <= '0;
      chan_r    <= '0;
      res_r     <= '0;
      busy_r    <= 1'b0;
      sample_r  <= 1'b0;
      rdata_r   <= '0;
      swt_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      pend_r    <= pend_nxt;
      pend_ch_r <= pend_ch_nxt;
      chan_r    <= chan_nxt;
      res_r     <= res_nxt;
      busy_r    <= busy_nxt;
      sample_r  <= sample_nxt;
      rdata_r   <= rdata_nxt;
      swt_r     <= swt_nxt;
    end
  end

  assign o_rdata    = rdata_r;
  assign o_chan_sel = chan_r;
  assign o_sample   = sample_r;
  assign o_dac_code = code;
  assign o_busy     = busy_r;
  assign o_swt_irq  = swt_r;

  // Cycles spent busy since the last start, kept apart from cnt_r so that the
  // length checks do not merely repeat the sequencer's own compare
  logic [CNT_BITS-1:0] run_len_r, run_len_nxt;

  always_comb begin
    run_len_nxt = run_len_r;
    if (start) begin
      run_len_nxt = '0;
    end else if (busy_r && run_len_r != '1) begin
      run_len_nxt = run_len_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      run_len_r <= '0;
    end else begin
      run_len_r <= run_len_nxt;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_done_count: assert property (done |-> cnt_r == 7'd87 && state_r == ACC_CONVERT)
    else $error("conversion did not end at 88 states");
  a_sample_open: assert property (start |=> o_sample && cnt_r == '0)
    else $error("sample window not opened at start");
  a_sample_len: assert property ($fell(o_sample) |-> cnt_r == 7'd4)
    else $error("sample window not 4 states");
  a_trial_bit: assert property (trial |=> o_dac_code[$past(bit_idx)])
    else $error("trial bit not set");
  a_channel_load: assert property (go_now |=> o_chan_sel == $past(i_wdata[2:0]))
    else $error("channel not taken from command");
  a_deferred_go: assert property (evt_go |=> state_r == ACC_SAMPLE && !pend_r)
    else $error("deferred start not taken once");
  a_restart_now: assert property (start && busy_r |=> cnt_r == '0 && busy_r)
    else $error("running conversion not restarted");
  a_result_clear: assert property (start |=> res_r == '0)
    else $error("result not cleared at start");
  a_status_soon: assert property (start |-> ##[1:8] o_busy)
    else $error("status not set within 8 states");
  a_busy_hold: assert property (o_busy && !done && !start |=> o_busy)
    else $error("busy dropped before completion");
  a_busy_end: assert property (done && !start |=> !o_busy)
    else $error("busy stuck after completion");
  a_irq_cause: assert property (o_swt_irq |-> $past(pend_r))
    else $error("timer interrupt without timed start");
  a_read_hi: assert property (i_rd && i_addr == 8'h03 |=> o_rdata == $past(res_r[9:2]))
    else $error("high result byte wrong");
  a_run_length: assert property (done |-> run_len_r == CNT_BITS'(CONV_CLKS - 1))
    else $error("conversion length differs from 88 states");
  a_busy_len: assert property ($fell(o_busy) |-> run_len_r == CNT_BITS'(CONV_CLKS))
    else $error("status busy for wrong number of states");
  a_code_clear: assert property (start |=> o_dac_code == '0)
    else $error("trial code not cleared at start");
  a_read_lo: assert property (i_rd && i_addr == ADR_CMD_RES_LO |=>
    o_rdata[RES_BSY_BIT] == $past(busy_r) && o_rdata[RES_CH_LSB +: CHAN_BITS] == $past(chan_r))
    else $error("low result byte wrong");
  a_read_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data present without a read");
  a_evt_ignored: assert property (i_evt_start && !pend_r |=> !o_swt_irq)
    else $error("timed start taken with nothing pending");

  c_full_conv: cover property (done && run_len_r == CNT_BITS'(CONV_CLKS - 1));
  c_deferred_quiet: cover property (evt_go && !i_evt_irq);
  c_restart: cover property (start && busy_r);
  c_evt_start: cover property (evt_go && i_evt_irq);
endmodule // acc_ctrl

//--- test/acc_sensor_model.sv
// Purpose: Eight sensor levels and the trial comparator at the analog pins
// Assumes: Levels hold steady across a conversion
// Notes:   Answers at once; the design's synchroniser absorbs the lag
`timescale 1ns/1ps
module acc_sensor_model
  import acc_pkg::*;
(
  input  wire logic [8*RES_BITS-1:0] i_levels,
  input  wire logic [CHAN_BITS-1:0]  i_chan,
  input  wire logic [RES_BITS-1:0]   i_code,
  output logic                       o_cmp
);
  logic [RES_BITS-1:0] lvl;
  assign lvl   = i_levels[i_chan*RES_BITS +: RES_BITS];
  assign o_cmp = (lvl >= i_code);
endmodule // acc_sensor_model

//--- test/test_adc_conversion_control.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: One state time per clock; model answers on the selected channel
// Notes:   Seeded random levels plus full-scale, zero, restart and timed starts
`timescale 1ns/1ps
module test_adc_conversion_control;
  import acc_pkg::*;
  logic                 i_clk, i_nrst, i_wr, i_rd, i_evt_start, i_evt_irq, i_cmp;
  logic [7:0]           i_addr, i_wdata, o_rdata, hi;
  logic [CHAN_BITS-1:0] o_chan_sel;
  logic [RES_BITS-1:0]  o_dac_code;
  logic                 o_sample, o_busy, o_swt_irq;
  logic [79:0]          lvls;
  int                   num_errors, tests_run, seed, cyc;

  acc_ctrl acc_ctrl_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_evt_start(i_evt_start),
    .i_evt_irq(i_evt_irq), .i_cmp(i_cmp), .o_chan_sel(o_chan_sel), .o_sample(o_sample),
    .o_dac_code(o_dac_code), .o_busy(o_busy), .o_swt_irq(o_swt_irq));
  acc_sensor_model acc_sensor_model_inst (.i_levels(lvls), .i_chan(o_chan_sel),
    .i_code(o_dac_code), .o_cmp(i_cmp));

  initial begin
    i_clk = 0;
    forever #12.5 i_clk = ~i_clk;
  end

  // About 14 conversions of under 100 cycles each; generous ceiling
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      conclude();
    end
  end

  function automatic logic [15:0] exp_res(input logic [9:0] lv);
    return {6'h0, lv};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic evt(input logic irq);
    @(posedge i_clk);
    i_evt_start <= 1'b1;
    i_evt_irq   <= irq;
    @(posedge i_clk);
    i_evt_start <= 1'b0;
    i_evt_irq   <= 1'b0;
  endtask

  task automatic meas(output int n, output int s);
    n = 0;
    s = 0;
    for (int i = 0; i < 200 && o_busy === 1'b1; i++) begin
      n += 1;
      s += int'(o_sample);
      @(posedge i_clk);
      #1;
    end
  endtask

  // Bytes fetched one at a time, never as a word
  task automatic fetch(input logic [2:0] ch, input logic [9:0] lv);
    logic [7:0] h, l;
    int         n, s;
    meas(n, s);
    check(16'(n), 16'(CONV_CLKS));
    check(16'(s), 16'(SAMPLE_CLKS));
    rd(ADR_RES_HI, h);
    rd(ADR_CMD_RES_LO, l);
    check({6'h0, h, l[7:6]}, exp_res(lv));
    check({10'h0, l[5:0]}, {13'h0, ch});
  endtask

  task automatic convert(input logic [2:0] ch, input logic [9:0] lv);
    lvls[ch*10 +: 10] = lv;
    wr(ADR_CMD_RES_LO, {4'h0, 1'b1, ch});
    #1;
    check({15'h0, o_busy}, 16'h1);
    check({13'h0, o_chan_sel}, {13'h0, ch});
    check({6'h0, o_dac_code}, 16'h0);
    fetch(ch, lv);
  endtask

  task automatic deferred(input logic [2:0] ch, input logic [9:0] lv, input logic irq);
    lvls[ch*10 +: 10] = lv;
    wr(ADR_CMD_RES_LO, {5'h0, ch});
    repeat (10) @(posedge i_clk);
    #1;
    check({15'h0, o_busy}, 16'h0);
    evt(irq);
    #1;
    check({15'h0, o_swt_irq}, {15'h0, irq});
    check({15'h0, o_busy}, 16'h1);
    fetch(ch, lv);
  endtask

  initial begin
    seed = 3449;
    {num_errors, tests_run, cyc} = '0;
    {i_nrst, i_wr, i_rd, i_evt_start, i_evt_irq} = '0;
    {i_addr, i_wdata} = '0;
    lvls = '0;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    convert(3'h0, 10'h3ff);
    convert(3'h7, 10'h000);
    for (int k = 0; k < 8; k++) convert(3'(k), 10'($random(seed)));
    $display("test channels finished");
    wr(8'h10, 8'h08);
    #1;
    check({15'h0, o_busy}, 16'h0);
    rd(8'h05, hi);
    check({8'h0, hi}, 16'h0);
    $display("test unmapped finished");
    lvls[20 +: 10] = 10'h3c3;
    wr(ADR_CMD_RES_LO, 8'h0a);
    rd(ADR_RES_HI, hi);
    check({8'h0, hi}, 16'h0);
    repeat (30) @(posedge i_clk);
    convert(3'h5, 10'h2a5);
    $display("test restart finished");
    deferred(3'h6, 10'h155, 1'b1);
    deferred(3'h1, 10'($random(seed)), 1'b0);
    evt(1'b1);
    #1;
    check({14'h0, o_busy, o_swt_irq}, 16'h0);
    $display("test timed start finished");
    conclude();
  end
endmodule // test_adc_conversion_control
